// [test/tb_zcd_top.sv]
`timescale 1ns/10ps
module tb_zcd_top;
   import zcd_pkg::*;
   logic aclk, aresetn, ce, fuse, sink, det_en, irq;
   logic awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   logic [13:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   zcd_pin_t pin;
   int miscompares, n_tests;

   // 100 MHz clock
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   zcd_top dut (.aclk(aclk), .aresetn(aresetn), .ce(ce),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .fuse_disable(fuse), .comparator_sink(sink), .pin_ctrl(pin),
      .detector_enable(det_en), .irq(irq));

   zcd_ac_line line (.comparator_sink(sink));

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic tick(input int n);
      repeat (n) @(posedge aclk);
   endtask : tick

   // aw and w offered together, each dropped when its own ready is seen
   task automatic wr(input logic [13:0] a, input logic [7:0] d);
      int n;
      logic aw_ok;
      logic w_ok;
      n = 0;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= {24'h00_0000, d};
      wvalid <= 1'b1;
      while (!(aw_ok && w_ok) && n < 50) begin
         @(posedge aclk);
         n++;
         if (!aw_ok && awready) begin
            aw_ok = 1'b1;
            awvalid <= 1'b0;
         end
         if (!w_ok && wready) begin
            w_ok = 1'b1;
            wvalid <= 1'b0;
         end
      end
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
      end while (!bvalid && n < 50);
      bready <= 1'b0;
      chk("bus wait", 32'h0000_0000, {31'h0, n >= 50});
      chk("bresp", {30'h0, ZCD_RESP_OKAY}, {30'h0, bresp});
   endtask : wr

   // read with expected data and response
   task automatic rdc(input string what, input logic [13:0] a, input logic [31:0] exp,
         input logic [1:0] resp);
      int n;
      n = 0;
      araddr <= a;
      arvalid <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
      end while (!arready && n < 50);
      arvalid <= 1'b0;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
      end while (!rvalid && n < 50);
      rready <= 1'b0;
      chk(what, exp, rdata);
      chk("rresp", {30'h0, resp}, {30'h0, rresp});
      chk("bus wait", 32'h0000_0000, {31'h0, n >= 50});
   endtask : rdc

   task automatic t_reset();
      chk("enable", 32'h0000_0001, {31'h0, det_en});
      chk("drive", 32'h0000_0001, {31'h0, pin.drive_en});
      rdc("ctrl", ZCD_CTRL_ADDR, 32'h0000_0000, ZCD_RESP_OKAY);
      rdc("stat", ZCD_STAT_ADDR, 32'h0000_0000, ZCD_RESP_OKAY);
      rdc("unmapped", 14'h0010, 32'h0000_0000, ZCD_RESP_SLVERR);
      chk("irq", 32'h0000_0000, {31'h0, irq});
   endtask : t_reset

   task automatic t_enable();
      fuse <= 1'b1;
      tick(2);
      chk("enable", 32'h0000_0000, {31'h0, det_en});
      chk("pin_oe", 32'h0000_0000, {31'h0, pin.pin_oe});
      wr(ZCD_CTRL_ADDR, 8'h80);
      tick(1);
      chk("enable", 32'h0000_0001, {31'h0, det_en});
      chk("pin", 32'h0000_0003, {30'h0, pin});
      wr(ZCD_CFG_ADDR, 8'h01);
      tick(1);
      chk("enable", 32'h0000_0000, {31'h0, det_en});
      fuse <= 1'b0;
      tick(2);
      chk("enable", 32'h0000_0001, {31'h0, det_en});
      wr(ZCD_CTRL_ADDR, 8'h00);
      tick(1);
      chk("enable", 32'h0000_0001, {31'h0, det_en});
      wr(ZCD_CFG_ADDR, 8'h00);
   endtask : t_enable

   task automatic t_out();
      line.swing(1'b1, 3);
      tick(5);
      rdc("out", ZCD_CTRL_ADDR, 32'h0000_0020, ZCD_RESP_OKAY);
      wr(ZCD_CTRL_ADDR, 8'h10);
      tick(4);
      rdc("out inv", ZCD_CTRL_ADDR, 32'h0000_0010, ZCD_RESP_OKAY);
      // a write with byte lane 0 off must leave control as it is
      wstrb <= 4'h0;
      wr(ZCD_CTRL_ADDR, 8'h80);
      wstrb <= 4'hf;
      rdc("strobe off", ZCD_CTRL_ADDR, 32'h0000_0010, ZCD_RESP_OKAY);
      // read-only and unused bits ignore the write
      wr(ZCD_CTRL_ADDR, 8'hff);
      tick(4);
      rdc("ctrl", ZCD_CTRL_ADDR, 32'h0000_0093, ZCD_RESP_OKAY);
      wr(ZCD_CTRL_ADDR, 8'h00);
      tick(4);
      wr(ZCD_STAT_ADDR, 8'h01);
   endtask : t_out

   task automatic t_edges();
      wr(ZCD_CTRL_ADDR, 8'h02);
      wr(ZCD_MASK_ADDR, 8'h01);
      line.swing(1'b0, 7);
      tick(5);
      rdc("fall off", ZCD_STAT_ADDR, 32'h0000_0000, ZCD_RESP_OKAY);
      line.swing(1'b1, 2);
      tick(5);
      rdc("rise", ZCD_STAT_ADDR, 32'h0000_0001, ZCD_RESP_OKAY);
      chk("irq", 32'h0000_0001, {31'h0, irq});
      wr(ZCD_STAT_ADDR, 8'h01);
      tick(2);
      rdc("cleared", ZCD_STAT_ADDR, 32'h0000_0000, ZCD_RESP_OKAY);
      chk("irq", 32'h0000_0000, {31'h0, irq});
      wr(ZCD_CTRL_ADDR, 8'h01);
      line.swing(1'b0, 4);
      tick(5);
      rdc("fall", ZCD_STAT_ADDR, 32'h0000_0001, ZCD_RESP_OKAY);
      wr(ZCD_MASK_ADDR, 8'h00);
      tick(2);
      chk("irq masked", 32'h0000_0000, {31'h0, irq});
      wr(ZCD_STAT_ADDR, 8'h01);
      // rise with only the fall enable set must not flag
      line.swing(1'b1, 6);
      tick(5);
      rdc("rise off", ZCD_STAT_ADDR, 32'h0000_0000, ZCD_RESP_OKAY);
   endtask : t_edges

   // output is high here; flipping polarity alone gives a falling edge
   task automatic t_pol();
      tick(2);
      wr(ZCD_CTRL_ADDR, 8'h11);
      tick(4);
      rdc("pol edge", ZCD_STAT_ADDR, 32'h0000_0001, ZCD_RESP_OKAY);
   endtask : t_pol

   // clock enable low holds the synchroniser, so a crossing only flags after it returns
   task automatic t_freeze();
      wr(ZCD_STAT_ADDR, 8'h01);
      wr(ZCD_MASK_ADDR, 8'h01);
      wr(ZCD_CTRL_ADDR, 8'h12);
      ce <= 1'b0;
      line.swing(1'b0, 3);
      tick(6);
      chk("frozen irq", 32'h0000_0000, {31'h0, irq});
      ce <= 1'b1;
      tick(5);
      chk("thawed irq", 32'h0000_0001, {31'h0, irq});
      wr(ZCD_STAT_ADDR, 8'h01);
   endtask : t_freeze

   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : complete_run

   // hang guard, far beyond the 140 or so cycles the tests take
   initial begin
      #200_000;
      miscompares++;
      complete_run();
   end

   // reset, then the scenarios in order
   initial begin
      aresetn = 1'b0;
      ce = 1'b1;
      fuse = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
      awaddr = 14'h0000;
      araddr = 14'h0000;
      wdata = 32'h0000_0000;
      wstrb = 4'hf;
      miscompares = 0;
      n_tests = 0;
      tick(8);
      aresetn <= 1'b1;
      tick(1);
      t_reset();
      t_enable();
      t_out();
      t_edges();
      t_pol();
      t_freeze();
      complete_run();
   end
endmodule : tb_zcd_top

// [test/zcd_ac_line.sv]
`timescale 1ns/10ps
// ac line seen through the series resistor, reduced to the comparator level
module zcd_ac_line (
   // comparator level towards the detector
   output logic comparator_sink
);
   // starts on the sourcing side
   initial begin
      comparator_sink = 1'b0;
   end

   // level lands off the clock grid, so the synchroniser sees a truly async edge
   task automatic swing(input logic sink, input int settle_ns);
      #(settle_ns);
      comparator_sink = sink;
   endtask : swing
endmodule : zcd_ac_line

// [verilog/zcd_edge.sv]
`timescale 1ns/10ps
// edge detector with per-direction enables
module zcd_edge
   import zcd_pkg::*;
(
   // clock
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   // level and enables
   input wire logic level,
   input wire logic rise_en,
   input wire logic fall_en,
   // event pulse
   output logic hit
);
   logic prev_reg;
   logic prev_next;

   always_comb begin
      prev_next = level;
      hit = ce & ((rise_en & level & ~prev_reg) | (fall_en & ~level & prev_reg));
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prev_reg <= 1'b0;
      end else if (ce) begin
         prev_reg <= prev_next;
      end
   end
endmodule : zcd_edge

// [verilog/zcd_pkg.sv]
// Contract
// - detection and flagging unaffected by sleep
// - fuse cleared means detector active from reset
// - fuse set, enable bit one: pin drives current; here only while module disable is clear
// - fuse set, enable zero: pin follows remap/direction
// - fuse cleared: enable bit has no effect
// - status bit shows sink state, polarity adjusted
// - polarity bit inverts logic output
// - rise enable: low-to-high sets event flag
// - fall enable: high-to-low sets event flag
// - software clears flag; set wins over clear
// - polarity change edge can set flag always; here only while rise or fall enable is set
package zcd_pkg;
   // byte addresses; control sits at word index 0x91f, so its byte address is four times that
   localparam logic [11:0] ZCD_CTRL_INDEX = 12'h091f;
   localparam logic [13:0] ZCD_CTRL_ADDR = {ZCD_CTRL_INDEX, 2'b00};
   localparam logic [13:0] ZCD_STAT_ADDR = 14'h0000;
   localparam logic [13:0] ZCD_MASK_ADDR = 14'h0004;
   localparam logic [13:0] ZCD_CFG_ADDR = 14'h0008;
   // control field positions
   localparam int ZCD_SWEN_BIT = 7;
   localparam int ZCD_OUT_BIT = 5;
   localparam int ZCD_INV_BIT = 4;
   localparam int ZCD_RISE_BIT = 1;
   localparam int ZCD_FALL_BIT = 0;
   // status/mask bit 0 is the crossing event flag; cfg bit 0 is module disable
   localparam int ZCD_FLAG_BIT = 0;
   localparam int ZCD_MD_BIT = 0;
   localparam logic [7:0] ZCD_CTRL_RESET = 8'h00;
   localparam logic [1:0] ZCD_RESP_OKAY = 2'b00;
   localparam logic [1:0] ZCD_RESP_SLVERR = 2'b10;

   // control fields as software sees them
   typedef struct packed {
      logic sw_enable;
      logic invert;
      logic rise_en;
      logic fall_en;
   } zcd_ctrl_t;

   // pin-side signals
   typedef struct packed {
      logic drive_en;
      logic pin_oe;
   } zcd_pin_t;
endpackage : zcd_pkg

// [verilog/zcd_sync.sv]
`timescale 1ns/10ps
// two-flop synchroniser for the analog comparator level
module zcd_sync
   import zcd_pkg::*;
(
   // clock
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   // data
   input wire logic async_in,
   output logic sync_out
);
   logic s1_reg;
   logic s1_next;
   logic s2_next;

   always_comb begin
      s1_next = async_in;
      s2_next = s1_reg; // first stage read only here
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s1_reg <= 1'b0;
         sync_out <= 1'b0;
      end else if (ce) begin
         s1_reg <= s1_next;
         sync_out <= s2_next;
      end
   end
endmodule : zcd_sync

// [verilog/zcd_top.sv]
`timescale 1ns/10ps
// zero-cross detector control, status and event logic behind an axi4-lite slave
module zcd_top
   import zcd_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   // axi4-lite write address
   input wire logic [13:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read address
   input wire logic [13:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // axi4-lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // configuration fuse and analog side
   input wire logic fuse_disable,
   input wire logic comparator_sink,
   // pin ownership
   output zcd_pin_t pin_ctrl,
   output logic detector_enable,
   // interrupt
   output logic irq
);
   zcd_ctrl_t ctrl_reg, ctrl_next;
   logic flag_reg, flag_next;
   logic mask_reg, mask_next;
   logic md_reg, md_next;
   logic aw_got_reg, aw_got_next;
   logic w_got_reg, w_got_next;
   logic [13:0] awaddr_reg, awaddr_next;
   logic [31:0] wdata_reg, wdata_next;
   logic wstrb0_reg, wstrb0_next;
   logic bvalid_reg, bvalid_next;
   logic [1:0] bresp_reg, bresp_next;
   logic rvalid_reg, rvalid_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [1:0] rresp_reg, rresp_next;
   logic sink_sync;
   logic out_level;
   logic pol_prev_reg;
   logic pol_edge;
   logic edge_hit;
   logic wr_fire;
   logic [31:0] wd;
   logic [13:0] wa;

   // comparator crosses into the clock domain before anything reads it
   zcd_sync u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .async_in(comparator_sink),
      .sync_out(sink_sync)
   );

   // polarity-adjusted output; 1 means sinking when not inverted
   assign out_level = sink_sync ^ ctrl_reg.invert;

   // no sleep input exists, so nothing here gates on it
   zcd_edge u_edge (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .level(out_level),
      .rise_en(ctrl_reg.rise_en),
      .fall_en(ctrl_reg.fall_en),
      .hit(edge_hit)
   );

   // a polarity write flips out_level; pol_edge sets the flag in either direction, but only while rise or fall enable is set
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pol_prev_reg <= 1'b0;
      end else if (ce) begin
         pol_prev_reg <= ctrl_reg.invert;
      end
   end
   assign pol_edge = ce & (pol_prev_reg != ctrl_reg.invert);

   // enable chain: fuse cleared keeps it on; module disable only acts when the fuse is set
   always_comb begin
      if (!fuse_disable) begin
         detector_enable = 1'b1;
      end else begin
         detector_enable = ctrl_reg.sw_enable & ~md_reg;
      end
      pin_ctrl.drive_en = detector_enable;
      pin_ctrl.pin_oe = detector_enable; // low hands the pin back to remap/direction
   end

   assign irq = flag_reg & mask_reg;

   // write handshake: address and data accepted independently
   assign s_axi_awready = ~aw_got_reg & ~bvalid_reg;
   assign s_axi_wready = ~w_got_reg & ~bvalid_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_arready = ~rvalid_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;

   // register write side and flag update
   always_comb begin
      aw_got_next = aw_got_reg;
      w_got_next = w_got_reg;
      awaddr_next = awaddr_reg;
      wdata_next = wdata_reg;
      wstrb0_next = wstrb0_reg;
      bvalid_next = bvalid_reg;
      bresp_next = bresp_reg;
      ctrl_next = ctrl_reg;
      mask_next = mask_reg;
      md_next = md_reg;
      flag_next = flag_reg;
      wr_fire = 1'b0;
      wa = awaddr_reg;
      wd = wdata_reg;
      if (s_axi_awvalid && s_axi_awready) begin
         aw_got_next = 1'b1;
         awaddr_next = s_axi_awaddr;
         wa = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_got_next = 1'b1;
         wdata_next = s_axi_wdata;
         wstrb0_next = s_axi_wstrb[0];
         wd = s_axi_wdata;
      end
      if (aw_got_next && w_got_next && !bvalid_reg) begin
         wr_fire = 1'b1;
         aw_got_next = 1'b0;
         w_got_next = 1'b0;
         bvalid_next = 1'b1;
         bresp_next = ZCD_RESP_OKAY;
         if (wstrb0_next) begin
            case ({wa[13:2], 2'b00})
               ZCD_CTRL_ADDR: begin
                  ctrl_next.sw_enable = wd[ZCD_SWEN_BIT];
                  ctrl_next.invert = wd[ZCD_INV_BIT];
                  ctrl_next.rise_en = wd[ZCD_RISE_BIT];
                  ctrl_next.fall_en = wd[ZCD_FALL_BIT];
               end
               ZCD_STAT_ADDR: begin
                  if (wd[ZCD_FLAG_BIT]) begin
                     flag_next = 1'b0; // write one to clear
                  end
               end
               ZCD_MASK_ADDR: mask_next = wd[ZCD_FLAG_BIT];
               ZCD_CFG_ADDR: md_next = wd[ZCD_MD_BIT];
               default: bresp_next = ZCD_RESP_SLVERR;
            endcase
         end else if (({wa[13:2], 2'b00} != ZCD_CTRL_ADDR) && ({wa[13:2], 2'b00} != ZCD_STAT_ADDR)
               && ({wa[13:2], 2'b00} != ZCD_MASK_ADDR) && ({wa[13:2], 2'b00} != ZCD_CFG_ADDR)) begin
            bresp_next = ZCD_RESP_SLVERR;
         end
      end
      if (bvalid_reg && s_axi_bready) begin
         bvalid_next = 1'b0;
      end
      // set after clear so a coincident edge is not lost
      if (edge_hit || (pol_edge && (ctrl_reg.rise_en || ctrl_reg.fall_en))) begin
         flag_next = 1'b1;
      end
   end

   // read side, one cycle after the address is taken
   always_comb begin
      rvalid_next = rvalid_reg;
      rdata_next = rdata_reg;
      rresp_next = rresp_reg;
      if (s_axi_arvalid && s_axi_arready) begin
         rvalid_next = 1'b1;
         rresp_next = ZCD_RESP_OKAY;
         rdata_next = 32'h0000_0000;
         case ({s_axi_araddr[13:2], 2'b00})
            ZCD_CTRL_ADDR: begin
               rdata_next[ZCD_SWEN_BIT] = ctrl_reg.sw_enable;
               rdata_next[ZCD_OUT_BIT] = out_level;
               rdata_next[ZCD_INV_BIT] = ctrl_reg.invert;
               rdata_next[ZCD_RISE_BIT] = ctrl_reg.rise_en;
               rdata_next[ZCD_FALL_BIT] = ctrl_reg.fall_en;
            end
            ZCD_STAT_ADDR: rdata_next[ZCD_FLAG_BIT] = flag_reg;
            ZCD_MASK_ADDR: rdata_next[ZCD_FLAG_BIT] = mask_reg;
            ZCD_CFG_ADDR: rdata_next[ZCD_MD_BIT] = md_reg;
            default: rresp_next = ZCD_RESP_SLVERR;
         endcase
      end else if (rvalid_reg && s_axi_rready) begin
         rvalid_next = 1'b0;
      end
   end

   // state registers, all frozen while ce is low
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_reg <= zcd_ctrl_t'({ZCD_CTRL_RESET[ZCD_SWEN_BIT], ZCD_CTRL_RESET[ZCD_INV_BIT],
            ZCD_CTRL_RESET[ZCD_RISE_BIT], ZCD_CTRL_RESET[ZCD_FALL_BIT]});
         flag_reg <= 1'b0;
         mask_reg <= 1'b0;
         md_reg <= 1'b0;
         aw_got_reg <= 1'b0;
         w_got_reg <= 1'b0;
         awaddr_reg <= 14'h0000;
         wdata_reg <= 32'h0000_0000;
         wstrb0_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= 2'b00;
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= 2'b00;
      end else if (ce) begin
         ctrl_reg <= ctrl_next;
         flag_reg <= flag_next;
         mask_reg <= mask_next;
         md_reg <= md_next;
         aw_got_reg <= aw_got_next;
         w_got_reg <= w_got_next;
         awaddr_reg <= awaddr_next;
         wdata_reg <= wdata_next;
         wstrb0_reg <= wstrb0_next;
         bvalid_reg <= bvalid_next;
         bresp_reg <= bresp_next;
         rvalid_reg <= rvalid_next;
         rdata_reg <= rdata_next;
         rresp_reg <= rresp_next;
      end
   end

   // fuse cleared forces the detector on
   a_fuse_forces_on: assert property (@(posedge aclk) disable iff (!aresetn)
      !fuse_disable |-> detector_enable && pin_ctrl.drive_en)
      else $error("detector off with fuse cleared");
   a_ignores_sw_enable: assert property (@(posedge aclk) disable iff (!aresetn)
      (!fuse_disable && !ctrl_reg.sw_enable) |-> detector_enable)
      else $error("enable bit affected fuse-cleared detector");

   // fuse set: enable bit and module disable own the pin
   a_sw_enable_on: assert property (@(posedge aclk) disable iff (!aresetn)
      (fuse_disable && ctrl_reg.sw_enable && !md_reg) |-> pin_ctrl.pin_oe)
      else $error("pin not driven when enabled");
   a_sw_disable_off: assert property (@(posedge aclk) disable iff (!aresetn)
      (fuse_disable && !ctrl_reg.sw_enable) |-> !pin_ctrl.pin_oe && !detector_enable)
      else $error("pin not released when disabled");
   a_md_disables: assert property (@(posedge aclk) disable iff (!aresetn)
      (fuse_disable && md_reg) |-> !detector_enable)
      else $error("module disable ignored");

   // readback of the status bit follows the synchronised level and polarity
   a_status_polarity: assert property (@(posedge aclk) disable iff (!aresetn)
      (ce && s_axi_arvalid && s_axi_arready
         && ({s_axi_araddr[13:2], 2'b00} == ZCD_CTRL_ADDR))
      |=> s_axi_rdata[ZCD_OUT_BIT] == ($past(sink_sync) ^ $past(ctrl_reg.invert)))
      else $error("status level wrong");
   a_sync_two_stage: assert property (@(posedge aclk) disable iff (!aresetn)
      (ce && $past(ce) && $past(ce, 2)) |-> sink_sync == $past(comparator_sink, 2))
      else $error("sync latency not two");

   // event flag: set by enabled edges, kept until software clears it
   a_rise_sets_flag: assert property (@(posedge aclk) disable iff (!aresetn)
      (ce && ctrl_reg.rise_en && $rose(out_level) && $stable(ctrl_reg.invert)) |=> flag_reg)
      else $error("rising edge missed");
   a_fall_sets_flag: assert property (@(posedge aclk) disable iff (!aresetn)
      (ce && ctrl_reg.fall_en && $fell(out_level) && $stable(ctrl_reg.invert)) |=> flag_reg)
      else $error("falling edge missed");
   a_set_beats_clear: assert property (@(posedge aclk) disable iff (!aresetn)
      (ce && edge_hit) |=> flag_reg)
      else $error("edge lost during clear");
   a_flag_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
      (flag_reg && !wr_fire) |=> flag_reg)
      else $error("flag dropped without a write");
   a_flag_needs_enable: assert property (@(posedge aclk) disable iff (!aresetn)
      (ce && !flag_reg && !ctrl_reg.rise_en && !ctrl_reg.fall_en) |=> !flag_reg)
      else $error("flag set with both edges disabled");
   a_pol_edge_flags: assert property (@(posedge aclk) disable iff (!aresetn)
      (ce && pol_edge && (ctrl_reg.rise_en || ctrl_reg.fall_en)) |=> flag_reg)
      else $error("polarity change did not flag");

   // bus answers and freeze
   a_write_answers: assert property (@(posedge aclk) disable iff (!aresetn)
      (ce && wr_fire) |=> s_axi_bvalid)
      else $error("write response missing");
   a_bresp_holds: assert property (@(posedge aclk) disable iff (!aresetn)
      (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   a_rdata_holds: assert property (@(posedge aclk) disable iff (!aresetn)
      (s_axi_rvalid && !s_axi_rready) |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
   a_ce_freezes: assert property (@(posedge aclk) disable iff (!aresetn)
      !ce |=> $stable(flag_reg) && $stable(ctrl_reg) && $stable(sink_sync))
      else $error("state moved while clock enable low");
endmodule : zcd_top
